// [inc/tbpe_defs.vh]
// constants for the three-bit port e block
`ifndef TBPE_DEFS_VH
`define TBPE_DEFS_VH

// register byte addresses on the axi4-lite bus
`define TBPE_ADDR_W 4
`define TBPE_OFS_PIN_LEVELS 4'h0
`define TBPE_OFS_OUT_LATCH 4'h4
`define TBPE_OFS_DIRECTION 4'h8
`define TBPE_OFS_ANALOG_CFG 4'hC

// field positions in the pin-level register
`define TBPE_BIT_PULLUP_D 7
`define TBPE_BIT_PULLUP_E 6
`define TBPE_PIN_MSB 2

// analog config: bits 7:5 belong to pins 2:0 (channels 7,6,5); 0 selects analog
`define TBPE_ANA_PIN_LSB 5
`define TBPE_ANA_PIN_MSB 7

// reset values
`define TBPE_RST_LATCH 3'h0
`define TBPE_RST_DIRECTION 3'h7
`define TBPE_RST_ANALOG_CFG 8'h00
`define TBPE_RST_PULLUP 1'h0

// axi response codes
`define TBPE_RESP_OKAY 2'h0
`define TBPE_RESP_SLVERR 2'h2

`endif

// [rtl/tbpe_sync.v]
// two-stage synchroniser for the port e pin inputs
`timescale 1ns/10ps
module tbpe_sync (
   input wire clk_in, // system clock
   input wire rst_in, // async reset, active high
   input wire [2:0] d_in, // raw pin levels
   output wire [2:0] q_out // synchronised levels
);

reg [2:0] stage1_reg;
reg [2:0] stage2_reg;

genvar i;
generate
   for (i = 0; i < 3; i = i + 1) begin : g_bit
      // the first stage feeds only the second stage
      always @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            stage1_reg[i] <= 1'b0;
            stage2_reg[i] <= 1'b0;
         end else begin
            stage1_reg[i] <= d_in[i];
            stage2_reg[i] <= stage1_reg[i];
         end
      end
   end
endgenerate

assign q_out = stage2_reg;

endmodule // tbpe_sync

// [rtl/tbpe_port.v]
// three-bit general-purpose port e with axi4-lite register access
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`include "tbpe_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - three individually configurable i/o pins, only on the larger package variant
// R2 - analog-selected pin disables its digital input and reads back as zero
// R3 - direction bit one makes the pin an input with its driver off
// R4 - direction bit zero makes the pin an output driving its latch bit
// R5 - direction keeps driver control in analog mode; software keeps analog pins inputs
// R6 - after power-on reset all three pins are analog inputs
// R7 - latch register reads return latch contents, not pin levels
// R8 - bit 6 of the pin-level register enables all three weak pull-ups
// R9 - an output pin always has its pull-up switched off
// R10 - power-on reset clears the pull-up enables
// R11 - output pins drive their latch bit regardless of analog selection
// R12 - pins 0,1,2 are analog channels 5,6,7, analog by default
// R13 - pin 0 outputs host read strobe when output, accepts it when input
// R14 - pin 1 outputs host write strobe when output, accepts it when input
// R15 - pin 2 only outputs the host byte enable when that function is used
// R16 - pin-level register: bit 7 port d pull-up, bit 6 this pull-up, 2:0 pins
// R17 - pull-up enable zero disables all, one enables pull-ups on input pads
// R18 - digital pin reads come through a two-stage synchroniser
module tbpe_port (
   input wire REF_CLK_IN, // 100 mhz system clock
   input wire SYS_RST_IN, // async power-on reset, active high
   // axi4-lite slave
   input wire [`TBPE_ADDR_W-1:0] S_AXI_AWADDR_IN, // write address
   input wire S_AXI_AWVALID_IN, // write address valid
   output wire S_AXI_AWREADY_OUT, // write address ready
   input wire [31:0] S_AXI_WDATA_IN, // write data
   input wire [3:0] S_AXI_WSTRB_IN, // write byte strobes
   input wire S_AXI_WVALID_IN, // write data valid
   output wire S_AXI_WREADY_OUT, // write data ready
   output wire [1:0] S_AXI_BRESP_OUT, // write response
   output wire S_AXI_BVALID_OUT, // write response valid
   input wire S_AXI_BREADY_IN, // write response ready
   input wire [`TBPE_ADDR_W-1:0] S_AXI_ARADDR_IN, // read address
   input wire S_AXI_ARVALID_IN, // read address valid
   output wire S_AXI_ARREADY_OUT, // read address ready
   output wire [31:0] S_AXI_RDATA_OUT, // read data
   output wire [1:0] S_AXI_RRESP_OUT, // read response
   output wire S_AXI_RVALID_OUT, // read data valid
   input wire S_AXI_RREADY_IN, // read data ready
   // pins
   input wire [2:0] PIN_E_IN, // pad input levels
   output wire [2:0] PIN_E_OUT, // pad output levels
   output wire [2:0] PIN_E_OE_OUT, // pad driver enables, high drives
   output wire [2:0] PIN_E_PULLUP_OUT, // weak pull-up enable per pad
   output wire PULLUP_ENABLE_D_OUT, // port d pull-up enable bit
   // analog converter side
   output wire [2:0] ANALOG_SELECT_OUT, // high: channel 7,6,5 uses pin 2,1,0
   // parallel host port side
   input wire HOST_PORT_EN_IN, // host port owns the pins
   input wire HOST_RD_STROBE_IN, // read strobe to drive out
   input wire HOST_WR_STROBE_IN, // write strobe to drive out
   input wire HOST_BYTE_EN_IN, // byte enable to drive out
   output wire HOST_RD_STROBE_OUT, // read strobe seen on pin 0
   output wire HOST_WR_STROBE_OUT // write strobe seen on pin 1
);

////////////////////////////////////////////////////////////////////////////////
// register state

reg [2:0] latch_reg;
reg [2:0] direction_reg;
reg [7:0] analog_cfg_reg;
reg pullup_e_reg;
reg pullup_d_reg;

wire [2:0] pin_sync;
wire [2:0] analog_sel;
wire [2:0] pin_read;
wire [2:0] host_drive;

// bus state
reg aw_held_reg;
reg [`TBPE_ADDR_W-1:0] aw_addr_reg;
reg w_held_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg bvalid_reg;
reg [1:0] bresp_reg;
reg rvalid_reg;
reg [31:0] rdata_reg;
reg [1:0] rresp_reg;

wire aw_take;
wire w_take;
wire ar_take;
wire do_write;
wire wr_lane0;
reg wr_hit;
reg [31:0] rd_word;
reg rd_hit;

////////////////////////////////////////////////////////////////////////////////
// pin input path

tbpe_sync u_sync (
   .clk_in(REF_CLK_IN),
   .rst_in(SYS_RST_IN),
   .d_in(PIN_E_IN),
   .q_out(pin_sync)
); // [R18]

// config bit clear means analog; pin i maps to bit 5+i (channels 5..7)
assign analog_sel = ~analog_cfg_reg[`TBPE_ANA_PIN_MSB:`TBPE_ANA_PIN_LSB]; // [R12] [R6]
assign ANALOG_SELECT_OUT = analog_sel;

// digital input is gated off for analog pins
assign pin_read = pin_sync & ~analog_sel; // [R2]

// strobe inputs are only meaningful while the pin is an input
assign HOST_RD_STROBE_OUT = direction_reg[0] & pin_read[0]; // [R13]
assign HOST_WR_STROBE_OUT = direction_reg[1] & pin_read[1]; // [R14]

////////////////////////////////////////////////////////////////////////////////
// pin output path

// host port signals replace the latch only when the port owns the pins
assign host_drive = {HOST_BYTE_EN_IN, HOST_WR_STROBE_IN, HOST_RD_STROBE_IN};

genvar gi;
generate
   for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin // [R1]
      // direction alone decides the driver, even when analog is selected
      assign PIN_E_OE_OUT[gi] = ~direction_reg[gi]; // [R3] [R4] [R5]
      // the driven value ignores analog selection
      assign PIN_E_OUT[gi] = HOST_PORT_EN_IN ? host_drive[gi] : latch_reg[gi]; // [R11] [R4]
      // pull-up only on inputs, shared enable
      assign PIN_E_PULLUP_OUT[gi] = pullup_e_reg & direction_reg[gi]; // [R8] [R9] [R17]
   end
endgenerate
// pin 2 has no strobe input role; its host function is output only [R15]

assign PULLUP_ENABLE_D_OUT = pullup_d_reg; // [R17]

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel

// address and data are taken independently; the write commits one cycle
// after both are held, which keeps the decode off the handshake path
assign S_AXI_AWREADY_OUT = ~aw_held_reg & ~bvalid_reg;
assign S_AXI_WREADY_OUT = ~w_held_reg & ~bvalid_reg;
assign aw_take = S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT;
assign w_take = S_AXI_WVALID_IN & S_AXI_WREADY_OUT;
assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
// all register fields sit in byte lane 0
assign wr_lane0 = w_strb_reg[0];

always @* begin
   case (aw_addr_reg)
      `TBPE_OFS_PIN_LEVELS: wr_hit = 1'b1;
      `TBPE_OFS_OUT_LATCH: wr_hit = 1'b1;
      `TBPE_OFS_DIRECTION: wr_hit = 1'b1;
      `TBPE_OFS_ANALOG_CFG: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
   endcase
end

always @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
   if (SYS_RST_IN) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {`TBPE_ADDR_W{1'b0}};
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TBPE_RESP_OKAY;
   end else begin
      if (aw_take) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= S_AXI_AWADDR_IN;
      end
      if (w_take) begin
         w_held_reg <= 1'b1;
         w_data_reg <= S_AXI_WDATA_IN;
         w_strb_reg <= S_AXI_WSTRB_IN;
      end
      if (do_write) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? `TBPE_RESP_OKAY : `TBPE_RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY_IN) begin
         bvalid_reg <= 1'b0;
      end
   end
end

assign S_AXI_BVALID_OUT = bvalid_reg;
assign S_AXI_BRESP_OUT = bresp_reg;

////////////////////////////////////////////////////////////////////////////////
// register updates

always @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
   if (SYS_RST_IN) begin
      latch_reg <= `TBPE_RST_LATCH;
      direction_reg <= `TBPE_RST_DIRECTION; // [R6] [R5]
      analog_cfg_reg <= `TBPE_RST_ANALOG_CFG; // [R6] [R12]
      pullup_e_reg <= `TBPE_RST_PULLUP; // [R10]
      pullup_d_reg <= `TBPE_RST_PULLUP; // [R10]
   end else if (do_write && wr_lane0) begin
      case (aw_addr_reg)
         `TBPE_OFS_PIN_LEVELS: begin
            // writing the pin register lands in the latch
            latch_reg <= w_data_reg[`TBPE_PIN_MSB:0];
            pullup_e_reg <= w_data_reg[`TBPE_BIT_PULLUP_E]; // [R8] [R16]
            pullup_d_reg <= w_data_reg[`TBPE_BIT_PULLUP_D]; // [R16]
         end
         `TBPE_OFS_OUT_LATCH: begin
            latch_reg <= w_data_reg[`TBPE_PIN_MSB:0];
         end
         `TBPE_OFS_DIRECTION: begin
            direction_reg <= w_data_reg[`TBPE_PIN_MSB:0]; // [R3] [R4]
         end
         `TBPE_OFS_ANALOG_CFG: begin
            analog_cfg_reg <= w_data_reg[7:0];
         end
         default: begin
            latch_reg <= latch_reg;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel

assign S_AXI_ARREADY_OUT = ~rvalid_reg;
assign ar_take = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;

always @* begin
   rd_word = 32'h00000000;
   rd_hit = 1'b1;
   case (S_AXI_ARADDR_IN)
      `TBPE_OFS_PIN_LEVELS: begin
         rd_word[`TBPE_BIT_PULLUP_D] = pullup_d_reg; // [R16]
         rd_word[`TBPE_BIT_PULLUP_E] = pullup_e_reg; // [R16]
         rd_word[`TBPE_PIN_MSB:0] = pin_read; // [R2] [R18]
      end
      `TBPE_OFS_OUT_LATCH: begin
         rd_word[`TBPE_PIN_MSB:0] = latch_reg; // [R7]
      end
      `TBPE_OFS_DIRECTION: begin
         rd_word[`TBPE_PIN_MSB:0] = direction_reg;
      end
      `TBPE_OFS_ANALOG_CFG: begin
         rd_word[7:0] = analog_cfg_reg;
      end
      default: begin
         rd_hit = 1'b0;
      end
   endcase
end

always @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
   if (SYS_RST_IN) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `TBPE_RESP_OKAY;
   end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? `TBPE_RESP_OKAY : `TBPE_RESP_SLVERR;
   end else if (rvalid_reg && S_AXI_RREADY_IN) begin
      rvalid_reg <= 1'b0;
   end
end

assign S_AXI_RVALID_OUT = rvalid_reg;
assign S_AXI_RDATA_OUT = rdata_reg;
assign S_AXI_RRESP_OUT = rresp_reg;

endmodule // tbpe_port

// [dv/tbpe_checker.sv]
// assertions on the port e block ports
`timescale 1ns/10ps
module tbpe_checker (
   input wire REF_CLK_IN, // clock
   input wire SYS_RST_IN, // reset
   input wire S_AXI_AWVALID_IN, // aw valid
   input wire S_AXI_AWREADY_OUT, // aw ready
   input wire S_AXI_WVALID_IN, // w valid
   input wire S_AXI_WREADY_OUT, // w ready
   input wire S_AXI_BVALID_OUT, // b valid
   input wire S_AXI_ARVALID_IN, // ar valid
   input wire S_AXI_ARREADY_OUT, // ar ready
   input wire [31:0] S_AXI_RDATA_OUT, // r data
   input wire S_AXI_RVALID_OUT, // r valid
   input wire S_AXI_RREADY_IN, // r ready
   input wire [2:0] PIN_E_OUT, // pad out
   input wire [2:0] PIN_E_OE_OUT, // pad oe
   input wire [2:0] PIN_E_PULLUP_OUT, // pull-ups
   input wire [2:0] ANALOG_SELECT_OUT, // analog pins
   input wire HOST_PORT_EN_IN, // host owns pins
   input wire HOST_RD_STROBE_IN, // rd strobe
   input wire HOST_WR_STROBE_IN, // wr strobe
   input wire HOST_BYTE_EN_IN, // byte enable
   input wire HOST_RD_STROBE_OUT, // rd strobe seen
   input wire HOST_WR_STROBE_OUT // wr strobe seen
);
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);
   sequence s_wr_take;
      S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
   endsequence
   sequence s_wr_resp;
      !S_AXI_BVALID_OUT ##1 S_AXI_BVALID_OUT;
   endsequence
   property p_wr_ans;
      s_wr_take |=> s_wr_resp;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
   property p_rd_ans;
      S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_r_hold;
      S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_pu_out;
      (PIN_E_PULLUP_OUT & PIN_E_OE_OUT) == 3'h0;
   endproperty
   a_pu_out: assert property (p_pu_out) else $error("pull-up on output");
   property p_pu_all;
      PIN_E_PULLUP_OUT == 3'h0 || (PIN_E_PULLUP_OUT | PIN_E_OE_OUT) == 3'h7;
   endproperty
   a_pu_all: assert property (p_pu_all) else $error("pull-ups split");
   property p_rd_dir;
      HOST_RD_STROBE_OUT |-> !PIN_E_OE_OUT[0] && !ANALOG_SELECT_OUT[0];
   endproperty
   a_rd_dir: assert property (p_rd_dir) else $error("rd strobe wrong mode");
   property p_wr_dir;
      HOST_WR_STROBE_OUT |-> !PIN_E_OE_OUT[1] && !ANALOG_SELECT_OUT[1];
   endproperty
   a_wr_dir: assert property (p_wr_dir) else $error("wr strobe wrong mode");
   property p_host;
      HOST_PORT_EN_IN |-> PIN_E_OUT == {HOST_BYTE_EN_IN, HOST_WR_STROBE_IN, HOST_RD_STROBE_IN};
   endproperty
   a_host: assert property (p_host) else $error("host drive wrong");
endmodule // tbpe_checker
bind tbpe_port tbpe_checker u_chk (.REF_CLK_IN, .SYS_RST_IN, .S_AXI_AWVALID_IN,
   .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT,
   .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RVALID_OUT,
   .S_AXI_RREADY_IN, .PIN_E_OUT, .PIN_E_OE_OUT, .PIN_E_PULLUP_OUT, .ANALOG_SELECT_OUT,
   .HOST_PORT_EN_IN, .HOST_RD_STROBE_IN, .HOST_WR_STROBE_IN, .HOST_BYTE_EN_IN,
   .HOST_RD_STROBE_OUT, .HOST_WR_STROBE_OUT);

// [dv/tbpe_pad.sv]
// board-side pad model for port e
`timescale 1ns/10ps
module tbpe_pad (
   input wire logic clk_in, // clock
   input wire logic [2:0] out_in, // device level
   input wire logic [2:0] oe_in, // device drives
   input wire logic [2:0] pu_in, // weak pull-up
   input wire logic [2:0] ext_en_in, // board drives
   input wire logic [2:0] ext_in, // board level
   output wire logic [2:0] pad_out // pad level
);
   logic flip = 1'b0;
   // a floating pad toggles so it never reads as a lucky constant
   always @(posedge clk_in) flip <= ~flip;
   assign pad_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_in)
      | (~oe_in & ~ext_en_in & (pu_in | {3{flip}}));
endmodule // tbpe_pad

// [dv/tb_tbpe_port.sv]
// self-checking bench for the port e block
`timescale 1ns/10ps
module tb_tbpe_port;
   logic clk, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic hen = 1'b0, hrd = 1'b0, hwr = 1'b0, hbe = 1'b0;
   logic [3:0] awa = 4'h0, ara = 4'h0, wst = 4'hF;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] br, rr;
   logic [1:0] er = 2'h0;
   logic slow = 1'b0;
   logic awr, wr_r, bv, arr, rv, rso, wso, pud;
   logic [2:0] pad, po, poe, ppu, asel, xen = 3'h7, xv = 3'h7;
   int fail_count = 0, cmp_count = 0;
   tbpe_port DUT (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(awa),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
      .S_AXI_WSTRB_IN(wst), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r),
      .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry),
      .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
      .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
      .S_AXI_RREADY_IN(rry), .PIN_E_IN(pad), .PIN_E_OUT(po), .PIN_E_OE_OUT(poe),
      .PIN_E_PULLUP_OUT(ppu), .PULLUP_ENABLE_D_OUT(pud), .ANALOG_SELECT_OUT(asel),
      .HOST_PORT_EN_IN(hen), .HOST_RD_STROBE_IN(hrd), .HOST_WR_STROBE_IN(hwr),
      .HOST_BYTE_EN_IN(hbe), .HOST_RD_STROBE_OUT(rso), .HOST_WR_STROBE_OUT(wso));
   tbpe_pad u_pad (.clk_in(clk), .out_in(po), .oe_in(poe), .pu_in(ppu), .ext_en_in(xen),
      .ext_in(xv), .pad_out(pad));
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task close_out;
      $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task tmo;
      fail_count++;
      close_out();
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task c3(input logic [2:0] g, input logic [2:0] e);
      cmp({29'h0, g}, {29'h0, e});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int n;
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
         if (bv) break;
      end
      bry <= 1'b0;
      if (n == 40) tmo();
      c3({1'b0, br}, {1'b0, er});
      @(posedge clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      int n;
      ara <= a;
      arv <= 1'b1;
      // a slow read raises rready only once rvalid is seen, so the data must stand
      rry <= ~slow;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv && rry) break;
         if (rv) rry <= 1'b1;
      end
      rry <= 1'b0;
      if (n == 40) tmo();
      cmp(rd, {24'h0, e});
      c3({1'b0, rr}, {1'b0, er});
      @(posedge clk);
   endtask
   ////////////////////////////////////////
   task t_rst;
      c3(poe, 3'h0);
      c3(asel, 3'h7);
      c3(ppu, 3'h0);
      rdc(4'h8, 8'h07);
      rdc(4'hC, 8'h00);
      rdc(4'h4, 8'h00);
      rdc(4'h0, 8'h00);
   endtask
   task t_out;
      wr(4'hC, 8'hE0);
      wr(4'h4, 8'h05);
      wr(4'h8, 8'h02);
      c3(poe, 3'h5);
      c3(po, 3'h5);
      xv <= 3'h2;
      repeat (3) @(posedge clk);
      rdc(4'h0, 8'h07);
      rdc(4'h4, 8'h05);
      wr(4'hC, 8'h00);
      c3(po, 3'h5);
      rdc(4'h0, 8'h00);
   endtask
   task t_pu;
      xen <= 3'h0;
      wr(4'hC, 8'hE0);
      wr(4'h8, 8'h07);
      wr(4'h0, 8'h40);
      c3(ppu, 3'h7);
      repeat (3) @(posedge clk);
      rdc(4'h0, 8'h47);
      wr(4'h8, 8'h06);
      c3(ppu, 3'h6);
      wr(4'h0, 8'h80);
      c3(ppu, 3'h0);
      c3({2'h0, pud}, 3'h1);
   endtask
   task t_host;
      hen <= 1'b1;
      hrd <= 1'b1;
      hbe <= 1'b1;
      wr(4'h8, 8'h00);
      c3(po, 3'h5);
      c3(poe, 3'h7);
      // swap the strobe levels so a crossed pin mapping shows up
      hrd <= 1'b0;
      hwr <= 1'b1;
      @(posedge clk);
      c3(po, 3'h6);
      wr(4'h8, 8'h03);
      xen <= 3'h3;
      xv <= 3'h3;
      repeat (3) @(posedge clk);
      c3({1'b0, wso, rso}, 3'h3);
   endtask
   task t_err;
      // unmapped offsets answer with slverr and change nothing
      er <= 2'h2;
      wr(4'h2, 8'h07);
      rdc(4'h6, 8'h00);
      er <= 2'h0;
      // lane 0 strobe low: the write is answered but dropped
      wst <= 4'hE;
      wr(4'h4, 8'h02);
      wst <= 4'hF;
      rdc(4'h4, 8'h00);
      slow <= 1'b1;
      rdc(4'h8, 8'h03);
      slow <= 1'b0;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_rst();
      t_out();
      t_pu();
      t_host();
      t_err();
      close_out();
   end
endmodule // tb_tbpe_port
